// >>> rtl/mio_ports.sv
// five general-purpose i/o ports with latches and read-back; direction on a, c, d and e, open-drain on c and d
`timescale 1ns/1ps
module mio_ports (
  input wire logic sys_clk,
  input wire logic rst_n,
  input mio_pkg::mio_cpu_req_type cpu_req,
  output logic [mio_pkg::BUS_W-1:0] cpu_rdata,
  input wire logic stop_mode,
  input wire logic stop_output_enable,
  input wire logic [mio_pkg::PA_W-1:0] port_a_in,
  output mio_pkg::mio_pin_drv_type port_a_drv,
  input wire logic [mio_pkg::PB_W-1:0] port_b_in,
  output logic [mio_pkg::PB_W-1:0] port_b_out,
  output logic [mio_pkg::PB_W-1:0] port_b_oe,
  output logic port_b_bit0_int_set,
  input wire logic [mio_pkg::PC_W-1:0] port_c_in,
  output mio_pkg::mio_pin_drv_type port_c_drv,
  input wire logic [mio_pkg::PD_W-1:0] port_d_in,
  output mio_pkg::mio_pin_drv_type port_d_drv,
  input wire logic [mio_pkg::PE_W-1:0] port_e_in,
  output mio_pkg::mio_pin_drv_type port_e_drv,
  output logic analog_input_disable,
  output logic conversion_start
);
  import mio_pkg::*;

  logic [PA_W-1:0] port_a_direction_q, port_a_latch_q;
  logic [PB_W-1:0] port_b_latch_q;
  logic [PC_W-1:0] port_c_direction_q, port_c_latch_q, port_c_open_drain_sel_q;
  logic [PD_W-1:0] port_d_direction_q, port_d_latch_q, port_d_open_drain_sel_q;
  logic [PE_W-1:0] port_e_direction_q, port_e_latch_q;
  logic analog_input_disable_q;
  logic conversion_start_q;
  logic b0_level_q;
  logic [BUS_W-1:0] rdata_q;
  logic [BUS_W-1:0] rdata_d;

  logic [PA_W-1:0] a_pin;
  logic [PB_W-1:0] b_pin;
  logic [PC_W-1:0] c_pin;
  logic [PD_W-1:0] d_pin;
  logic [PE_W-1:0] e_pin;

  mio_pin_sync #(.W(PA_W)) u_sync_a (.sys_clk(sys_clk), .rst_n(rst_n), .pin_async(port_a_in), .pin_sync(a_pin));
  mio_pin_sync #(.W(PB_W)) u_sync_b (.sys_clk(sys_clk), .rst_n(rst_n), .pin_async(port_b_in), .pin_sync(b_pin));
  mio_pin_sync #(.W(PC_W)) u_sync_c (.sys_clk(sys_clk), .rst_n(rst_n), .pin_async(port_c_in), .pin_sync(c_pin));
  mio_pin_sync #(.W(PD_W)) u_sync_d (.sys_clk(sys_clk), .rst_n(rst_n), .pin_async(port_d_in), .pin_sync(d_pin));
  mio_pin_sync #(.W(PE_W)) u_sync_e (.sys_clk(sys_clk), .rst_n(rst_n), .pin_async(port_e_in), .pin_sync(e_pin));

  wire sel_a = cpu_req.port == MIO_SEL_A;
  wire sel_b = cpu_req.port == MIO_SEL_B;
  wire sel_c = cpu_req.port == MIO_SEL_C;
  wire sel_d = cpu_req.port == MIO_SEL_D;
  wire sel_e = cpu_req.port == MIO_SEL_E;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_a_direction_q <= PA_DIR_RST;
      port_a_latch_q <= PA_LAT_RST;
      port_b_latch_q <= PB_LAT_RST;
      port_c_direction_q <= PC_DIR_RST;
      port_c_latch_q <= PC_LAT_RST;
      port_c_open_drain_sel_q <= PC_OD_RST;
      port_d_direction_q <= PD_DIR_RST;
      port_d_latch_q <= PD_LAT_RST;
      port_d_open_drain_sel_q <= PD_OD_RST;
      port_e_direction_q <= PE_DIR_RST;
      port_e_latch_q <= PE_LAT_RST;
      analog_input_disable_q <= AIN_DIS_RST;
    end else begin
      if (cpu_req.wr_latch && sel_a) port_a_latch_q <= cpu_req.wdata[PA_W-1:0];
      if (cpu_req.wr_dir && sel_a) port_a_direction_q <= cpu_req.wdata[PA_W-1:0];
      if (cpu_req.wr_latch && sel_b) port_b_latch_q <= cpu_req.wdata[PB_W-1:0];
      if (cpu_req.wr_latch && sel_c) port_c_latch_q <= cpu_req.wdata[PC_W-1:0];
      if (cpu_req.wr_dir && sel_c) port_c_direction_q <= cpu_req.wdata[PC_W-1:0];
      if (cpu_req.wr_od && sel_c) port_c_open_drain_sel_q <= cpu_req.wdata[PC_W-1:0];
      if (cpu_req.wr_latch && sel_d) port_d_latch_q <= cpu_req.wdata[PD_W-1:0];
      if (cpu_req.wr_dir && sel_d) port_d_direction_q <= cpu_req.wdata[PD_W-1:0];
      if (cpu_req.wr_od && sel_d) port_d_open_drain_sel_q <= cpu_req.wdata[PD_W-1:0];
      if (cpu_req.wr_latch && sel_e) port_e_latch_q <= cpu_req.wdata[PE_W-1:0];
      if (cpu_req.wr_dir && sel_e) port_e_direction_q <= cpu_req.wdata[PE_W-1:0];
      if (cpu_req.wr_ain_dis) analog_input_disable_q <= cpu_req.wdata[0];
    end
  end

  // conversion starts on the write that clears the analog disable
  wire conv_start_d = cpu_req.wr_ain_dis && !cpu_req.wdata[0] && analog_input_disable_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      conversion_start_q <= 1'b0;
    end else begin
      conversion_start_q <= conv_start_d;
    end
  end

  // pin drivers; open drain drives only a low
  wire [PC_W-1:0] c_oe = port_c_direction_q & ~(port_c_open_drain_sel_q & port_c_latch_q);
  wire [PD_W-1:0] d_oe = port_d_direction_q & ~(port_d_open_drain_sel_q & port_d_latch_q);
  assign port_a_drv.o = {{(BUS_W-PA_W){1'b0}}, port_a_latch_q};
  assign port_a_drv.oe = {{(BUS_W-PA_W){1'b0}}, port_a_direction_q};
  assign port_c_drv.o = port_c_latch_q;
  assign port_c_drv.oe = c_oe;
  assign port_d_drv.o = port_d_latch_q;
  assign port_d_drv.oe = d_oe;
  assign port_e_drv.o = port_e_latch_q;
  assign port_e_drv.oe = port_e_direction_q;

  // port b is open-drain style: drives low for latch zero; bit0 floats in stop
  wire [PB_W-1:0] b_drive = ~port_b_latch_q;
  wire b0_float = stop_mode;
  assign port_b_out = '0;
  assign port_b_oe = {b_drive[PB_W-1:1], b_drive[PB_INT_BIT] & ~b0_float};

  // falling edge of the driven bit0 level sets the external interrupt latch
  wire b0_level = port_b_latch_q[PB_INT_BIT] & b_pin[PB_INT_BIT];
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // starts low: synced pins reset low, so no false fall after reset
      b0_level_q <= 1'b0;
    end else begin
      b0_level_q <= b0_level;
    end
  end
  assign port_b_bit0_int_set = b0_level_q & ~b0_level;

  // read-back selection
  wire [PB_W-1:0] b_rd = cpu_req.rmw ? port_b_latch_q : b_pin;
  wire [PC_W-1:0] c_rd = cpu_req.rmw ? ((port_c_open_drain_sel_q & port_c_latch_q) | (~port_c_open_drain_sel_q & c_pin))
                                     : c_pin;
  wire [PD_W-1:0] d_rd = cpu_req.rmw ? ((port_d_open_drain_sel_q & port_d_latch_q) | (~port_d_open_drain_sel_q & d_pin))
                                     : d_pin;
  wire [PE_W-1:0] e_live = analog_input_disable_q ? '0 : e_pin;
  wire [PE_W-1:0] e_rd = port_e_latch_q & ((port_e_direction_q & port_e_latch_q) | e_live | e_pin);
  assign rdata_d = sel_a ? {{(BUS_W-PA_W){1'b0}}, a_pin}
                 : sel_b ? {PB_UNDEF_FILL[BUS_W-1:PB_W], b_rd}
                 : sel_c ? c_rd
                 : sel_d ? d_rd
                 : sel_e ? e_rd
                 : '0;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (cpu_req.rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign cpu_rdata = rdata_q;
  assign analog_input_disable = analog_input_disable_q;
  assign conversion_start = conversion_start_q;

  a_reset_in_a: assert property (@(posedge sys_clk) !rst_n |=> port_a_drv.oe == '0)
    else $error("port a driving after reset");
  b_reset_one_a: assert property (@(posedge sys_clk) !rst_n |=> port_b_oe == '0)
    else $error("port b not released after reset");
  b0_stop_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n) stop_mode |-> !port_b_oe[0])
    else $error("port b bit0 driven in stop");
  b_rmw_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cpu_req.rd && cpu_req.rmw && sel_b |=> cpu_rdata[PB_W-1:0] == $past(port_b_latch_q))
    else $error("port b rmw not latch");
  c_od_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (port_c_drv.oe & port_c_drv.o & port_c_open_drain_sel_q) == '0)
    else $error("port c open drain drives high");
  e_reset_a: assert property (@(posedge sys_clk) !rst_n |=> analog_input_disable && port_e_drv.oe == '0)
    else $error("port e reset state wrong");
  e_zero_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cpu_req.rd && sel_e |=> (cpu_rdata & ~$past(port_e_latch_q)) == '0)
    else $error("port e zero latch reads one");
  conv_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conversion_start |-> $past(analog_input_disable_q) && !analog_input_disable_q)
    else $error("conversion start without clear");
  d_dir_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (port_d_drv.oe & ~port_d_direction_q) == '0)
    else $error("port d driven as input");
endmodule : mio_ports

// >>> rtl/mio_pkg.sv
// package: widths, reset values and carrier structs of the i/o port block
package mio_pkg;
  localparam int PA_W = 6;
  localparam int PB_W = 3;
  localparam int PC_W = 8;
  localparam int PD_W = 8;
  localparam int PE_W = 8;
  localparam int BUS_W = 8;
  localparam logic [PA_W-1:0] PA_DIR_RST = 6'h00;
  localparam logic [PA_W-1:0] PA_LAT_RST = 6'h00;
  localparam logic [PB_W-1:0] PB_LAT_RST = 3'h7;
  localparam logic [PC_W-1:0] PC_DIR_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_LAT_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_OD_RST = 8'h00;
  localparam logic [PD_W-1:0] PD_DIR_RST = 8'h00;
  localparam logic [PD_W-1:0] PD_LAT_RST = 8'h00;
  localparam logic [PD_W-1:0] PD_OD_RST = 8'h00;
  localparam logic [PE_W-1:0] PE_DIR_RST = 8'h00;
  localparam logic [PE_W-1:0] PE_LAT_RST = 8'h00;
  localparam logic AIN_DIS_RST = 1'h1;
  localparam logic [BUS_W-1:0] PB_UNDEF_FILL = 8'h00;
  localparam int PB_INT_BIT = 0;

  typedef enum logic [4:0] {
    MIO_SEL_A = 5'h01,
    MIO_SEL_B = 5'h02,
    MIO_SEL_C = 5'h04,
    MIO_SEL_D = 5'h08,
    MIO_SEL_E = 5'h10
  } mio_port_type;

  // cpu-side access for one cycle
  typedef struct packed {
    logic wr_latch;
    logic wr_dir;
    logic wr_od;
    logic wr_ain_dis;
    logic rd;
    logic rmw;
    mio_port_type port;
    logic [BUS_W-1:0] wdata;
  } mio_cpu_req_type;

  typedef struct packed {
    logic [BUS_W-1:0] o;
    logic [BUS_W-1:0] oe;
  } mio_pin_drv_type;
endpackage : mio_pkg

// >>> rtl/mio_pin_sync.sv
// three-flop pin synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module mio_pin_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;
  logic [W-1:0] out_d;
  assign agree = ~(s2_q ^ s3_q);
  assign out_d = (agree & s3_q) | (~agree & pin_sync);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_sync <= '0;
    end else begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_sync <= out_d;
    end
  end
endmodule : mio_pin_sync

// >>> verification/mio_pin_model.sv
// pin-side model: external sources joined with the port drivers
`timescale 1ns/1ps
module mio_pin_model (
  input mio_pkg::mio_pin_drv_type a_drv,
  input mio_pkg::mio_pin_drv_type c_drv,
  input mio_pkg::mio_pin_drv_type d_drv,
  input mio_pkg::mio_pin_drv_type e_drv,
  input wire logic [2:0] b_out,
  input wire logic [2:0] b_oe,
  input wire logic [5:0] ext_a,
  input wire logic [2:0] ext_b,
  input wire logic [7:0] ext_c,
  input wire logic [7:0] ext_d,
  input wire logic [7:0] ext_e,
  output logic [5:0] a_in,
  output logic [2:0] b_in,
  output logic [7:0] c_in,
  output logic [7:0] d_in,
  output logic [7:0] e_in
);
  import mio_pkg::*;
  // driven bits follow the driver, released bits follow the outside source
  assign a_in = (a_drv.o[5:0] & a_drv.oe[5:0]) | (ext_a & ~a_drv.oe[5:0]);
  assign b_in = (b_out & b_oe) | (ext_b & ~b_oe);
  assign c_in = (c_drv.o & c_drv.oe) | (ext_c & ~c_drv.oe);
  assign d_in = (d_drv.o & d_drv.oe) | (ext_d & ~d_drv.oe);
  assign e_in = (e_drv.o & e_drv.oe) | (ext_e & ~e_drv.oe);
endmodule : mio_pin_model

// >>> verification/tb_mcu_io_ports.sv
// self-checking bench for the i/o port block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_mcu_io_ports;
  import mio_pkg::*;
  logic sys_clk, rst_n, stop_mode, stop_output_enable, int_set, conv_start, ain_dis;
  mio_cpu_req_type cpu_req;
  mio_pin_drv_type a_drv, c_drv, d_drv, e_drv;
  logic [7:0] rdata, ext_c, ext_d, ext_e, rv, pc_in, pd_in, pe_in;
  logic [5:0] ext_a, pa_in;
  logic [2:0] ext_b, pb_in, pb_out, pb_oe;
  int num_errors = 0;
  int checks_done = 0;
  mio_ports DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(rdata), .stop_mode(stop_mode),
    .stop_output_enable(stop_output_enable), .port_a_in(pa_in), .port_a_drv(a_drv), .port_b_in(pb_in),
    .port_b_out(pb_out), .port_b_oe(pb_oe), .port_b_bit0_int_set(int_set), .port_c_in(pc_in), .port_c_drv(c_drv),
    .port_d_in(pd_in), .port_d_drv(d_drv), .port_e_in(pe_in), .port_e_drv(e_drv),
    .analog_input_disable(ain_dis), .conversion_start(conv_start));
  mio_pin_model pins (.a_drv(a_drv), .c_drv(c_drv), .d_drv(d_drv), .e_drv(e_drv), .b_out(pb_out), .b_oe(pb_oe),
    .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c), .ext_d(ext_d), .ext_e(ext_e),
    .a_in(pa_in), .b_in(pb_in), .c_in(pc_in), .d_in(pd_in), .e_in(pe_in));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_of_test;
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // k: 0 latch, 1 direction, 2 open-drain, 3 analog disable
  task automatic wr(input int k, input mio_port_type p, input logic [7:0] d);
    mio_cpu_req_type r;
    r = '0;
    r.port = p;
    r.wdata = d;
    r.wr_latch = (k == 0);
    r.wr_dir = (k == 1);
    r.wr_od = (k == 2);
    r.wr_ain_dis = (k == 3);
    @(negedge sys_clk) cpu_req = r;
    @(negedge sys_clk) cpu_req = '0;
  endtask : wr
  task automatic rd(input mio_port_type p, input logic m);
    mio_cpu_req_type r;
    r = '0;
    r.port = p;
    r.rd = 1'b1;
    r.rmw = m;
    repeat (6) @(negedge sys_clk);
    cpu_req = r;
    @(negedge sys_clk) cpu_req = '0;
    rv = rdata;
  endtask : rd
  // waits a few cycles for a one-cycle pulse
  task automatic catch_pulse(ref logic s, input string nm);
    for (int i = 0; i < 5; i++) begin
      if (s === 1'b1) return;
      @(negedge sys_clk);
    end
    num_errors++;
    $display("CHECK FAILED %s exp 1 got 0", nm);
    end_of_test();
  endtask : catch_pulse
  task automatic t_reset;
    `CHK("a oe", 8'h00, a_drv.oe)
    `CHK("c oe", 8'h00, c_drv.oe)
    `CHK("d oe", 8'h00, d_drv.oe)
    `CHK("e oe", 8'h00, e_drv.oe)
    `CHK("b oe", 3'h0, pb_oe)
    `CHK("ain dis", 1'b1, ain_dis)
    `CHK("b int idle", 1'b0, int_set)
    rd(MIO_SEL_B, 1'b1);
    `CHK("b latch", 8'h07, rv)
    rd(MIO_SEL_E, 1'b0);
    `CHK("e read", 8'h00, rv)
  endtask : t_reset
  task automatic t_port_a;
    wr(0, MIO_SEL_A, 8'h2A);
    wr(1, MIO_SEL_A, 8'h3F);
    `CHK("a oe", 8'h3F, a_drv.oe)
    `CHK("a o", 6'h2A, a_drv.o[5:0])
    wr(1, MIO_SEL_A, 8'h00);
    rd(MIO_SEL_A, 1'b0);
    `CHK("a pins", 8'h15, rv)
  endtask : t_port_a
  task automatic t_port_b;
    wr(0, MIO_SEL_B, 8'h07);
    repeat (6) @(negedge sys_clk);
    wr(0, MIO_SEL_B, 8'h06);
    catch_pulse(int_set, "b int");
    `CHK("b oe", 3'h1, pb_oe)
    rd(MIO_SEL_B, 1'b1);
    `CHK("b rmw", 8'h06, rv)
    rd(MIO_SEL_B, 1'b0);
    `CHK("b pins", 8'h02, rv)
    stop_mode = 1'b1;
    @(negedge sys_clk);
    `CHK("b stop", 1'b0, pb_oe[0])
    stop_mode = 1'b0;
  endtask : t_port_b
  task automatic t_od(input mio_port_type p);
    wr(0, p, 8'h3C);
    wr(2, p, 8'hF0);
    wr(1, p, 8'hFF);
    `CHK("od oe", 8'hCF, (p == MIO_SEL_C) ? c_drv.oe : d_drv.oe)
    rd(p, 1'b0);
    `CHK("od pins", 8'h2C, rv)
    rd(p, 1'b1);
    `CHK("od rmw", 8'h3C, rv)
    wr(1, p, 8'h00);
  endtask : t_od
  task automatic t_port_e;
    wr(0, MIO_SEL_E, 8'hFF);
    rd(MIO_SEL_E, 1'b0);
    `CHK("e in", 8'h5A, rv)
    wr(1, MIO_SEL_E, 8'hF0);
    `CHK("e oe", 8'hF0, e_drv.oe)
    rd(MIO_SEL_E, 1'b0);
    `CHK("e mix", 8'hFA, rv)
    wr(1, MIO_SEL_E, 8'h00);
    wr(0, MIO_SEL_E, 8'h00);
    wr(3, MIO_SEL_A, 8'h00);
    catch_pulse(conv_start, "conv start");
    `CHK("ain dis", 1'b0, ain_dis)
    rd(MIO_SEL_E, 1'b0);
    `CHK("e analog", 8'h00, rv)
  endtask : t_port_e
  task automatic t_mid_reset;
    @(negedge sys_clk) rst_n = 0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1;
    `CHK("a latch", 8'h00, a_drv.o)
    t_reset();
    rd(MIO_SEL_C, 1'b1);
    `CHK("c od rst", 8'hA5, rv)
  endtask : t_mid_reset
  initial begin
    rst_n = 0;
    cpu_req = '0;
    stop_mode = 0;
    stop_output_enable = 1;
    ext_a = 6'h15;
    ext_b = 3'h3;
    ext_c = 8'hA5;
    ext_d = 8'hA5;
    ext_e = 8'h5A;
    repeat (20) @(negedge sys_clk);
    rst_n = 1;
    t_reset();
    t_port_a();
    t_port_b();
    t_od(MIO_SEL_C);
    t_od(MIO_SEL_D);
    t_port_e();
    t_mid_reset();
    end_of_test();
  end
endmodule : tb_mcu_io_ports
